// ===== tap_defs.svh
// constants of the boundary-scan test access port: instruction codes,
// register lengths, capture patterns and reset values.
// assumes inclusion by bare name from the package and the design module.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

// -----------------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------------
`define TAP_IR_W 3
`define TAP_IR_EXTEST 3'h0
`define TAP_IR_IDCODE 3'h1
`define TAP_IR_SAMPLE_Z 3'h2
`define TAP_IR_SAMPLE 3'h4
`define TAP_IR_BYPASS 3'h7
`define TAP_IR_CAPTURE 2'h1
`define TAP_IR_CAPTURE_MSB 1'h0

// -----------------------------------------------------------------------
// data registers
// -----------------------------------------------------------------------
`define TAP_ID_W 32
`define TAP_BSR_W 110
`define TAP_BSR_OE_BIT 109
`define TAP_BSR_RST 110'h0
`define TAP_BYP_CAPTURE 1'h0

// -----------------------------------------------------------------------
// consecutive tms-high edges that always reach test-logic-reset
// -----------------------------------------------------------------------
`define TAP_RESET_TMS_EDGES 3'h5

`endif

// ===== tap_pkg.sv
// types of the boundary-scan test access port.
// assumes tap_defs.svh is on the include path.
`include "tap_defs.svh"

package tap_pkg;

	// the sixteen controller states
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_TEST_IDLE,
		SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		UPDATE_DR,
		SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
		UPDATE_IR
	} tap_state_t;

	// data register placed between tdi and tdo
	typedef enum logic [1:0] {
		SEL_BYPASS, SEL_IDCODE, SEL_BOUNDARY
	} dr_sel_t;

endpackage

// ===== sram_boundary_scan_tap.sv
// boundary-scan test access port of a synchronous burst memory.
// assumes tck comes from an external test controller and may stand still;
// ring_in is the pad ring seen in the memory clock domain.
//
// Behaviour
// [R1] standard boundary-scan state machine and instructions
// [R2] unused port: tester holds tck low
// [R3] tdi and tms pads pulled high
// [R4] unused port: tdo left unconnected
// [R5] self reset at power-up, memory unaffected
// [R6] inputs sampled on rising tck
// [R7] outputs change on falling tck
// [R8] tck clocks only the test logic
// [R9] instruction selects register between tdi, tdo
// [R10] tdi enters register msb
// [R11] tdo shows register lsb
// [R12] tdo driven only while shifting
// [R13] five tms-high edges reset the port
// [R14] three-bit instruction, identification after reset
// [R15] capture-ir loads 01 into two lsbs
// [R16] one-bit bypass register in shift-dr
// [R17] tdo high impedance outside shift states
`timescale 1ns/1ps
`include "tap_defs.svh"

module sram_boundary_scan_tap #(
	parameter logic [`TAP_ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [`TAP_BSR_W-1:0] ring_in,
	output logic tdo_q,
	output logic tdo_oe_q,
	output logic q_bus_hiz_q
);
	import tap_pkg::*;

	// -------------------------------------------------------------------
	// reset of the test domain
	// -------------------------------------------------------------------
	logic por_q;
	logic trst_s1_q;
	logic trst_s2_q;

	// power-up reset captured in the memory clock domain
	always_ff @(posedge clock) begin
		por_q <= sys_rst; // R5
	end

	// asserts at once, releases on tck; with tck held low it stays set
	always_ff @(posedge tck or posedge por_q) begin
		if (por_q) begin
			trst_s1_q <= 1'b1; // R5
			trst_s2_q <= 1'b1;
		end else begin
			trst_s1_q <= 1'b0;
			trst_s2_q <= trst_s1_q;
		end
	end

	// -------------------------------------------------------------------
	// register selection
	// -------------------------------------------------------------------
	// private codes fall back to the bypass bit
	function automatic dr_sel_t dr_sel(input logic [`TAP_IR_W-1:0] ir);
		case (ir)
			`TAP_IR_IDCODE: dr_sel = SEL_IDCODE;
			`TAP_IR_EXTEST, `TAP_IR_SAMPLE_Z, `TAP_IR_SAMPLE:
				dr_sel = SEL_BOUNDARY;
			default: dr_sel = SEL_BYPASS;
		endcase
	endfunction

	// -------------------------------------------------------------------
	// controller and registers, rising tck
	// -------------------------------------------------------------------
	tap_state_t state_q, state_d;
	logic [`TAP_IR_W-1:0] irs_q, irs_d; // instruction shift stage
	logic [`TAP_IR_W-1:0] ir_q, ir_d; // current instruction
	logic byp_q, byp_d;
	logic [`TAP_ID_W-1:0] id_q, id_d;
	logic [`TAP_BSR_W-1:0] bsr_q, bsr_d; // boundary shift stage
	logic [`TAP_BSR_W-1:0] upd_q, upd_d; // boundary preload/update stage
	logic [`TAP_BSR_W-1:0] ring_s1_q, ring_s2_q, ring_s3_q;
	logic [`TAP_BSR_W-1:0] ring_q, ring_d; // agreed pad ring value
	logic hiz_req_q, hiz_req_d;
	logic [2:0] tms_run_q, tms_run_d;

	// next values of the test domain, apart from the three pad-ring stages
	always_comb begin
		state_d = state_q;
		irs_d = irs_q;
		ir_d = ir_q;
		byp_d = byp_q;
		id_d = id_q;
		bsr_d = bsr_q;
		upd_d = upd_q;
		// a pad bit counts once the second and third stages agree
		ring_d = (ring_s2_q & ring_s3_q) | (ring_q & (ring_s2_q ^ ring_s3_q));
		// standard transitions on sampled tms
		case (state_q) // R1 R6
			TEST_LOGIC_RESET: state_d = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE: state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_DR: state_d = tms ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: state_d = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: state_d = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: state_d = tms ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: state_d = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: state_d = tms ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
			SELECT_IR: state_d = tms ? TEST_LOGIC_RESET : CAPTURE_IR; // R13
			CAPTURE_IR: state_d = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: state_d = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: state_d = tms ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: state_d = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: state_d = tms ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: state_d = tms ? SELECT_DR : RUN_TEST_IDLE;
			default: state_d = TEST_LOGIC_RESET;
		endcase
		// register actions of the present state
		case (state_q)
			TEST_LOGIC_RESET: begin
				ir_d = `TAP_IR_IDCODE; // R14
				upd_d = `TAP_BSR_RST;
			end
			CAPTURE_IR: irs_d = {`TAP_IR_CAPTURE_MSB, `TAP_IR_CAPTURE}; // R15
			SHIFT_IR: irs_d = {tdi, irs_q[`TAP_IR_W-1:1]}; // R10 R14
			UPDATE_IR: ir_d = irs_q; // R1
			CAPTURE_DR: begin
				case (dr_sel(ir_q)) // R9
					SEL_IDCODE: id_d = ID_CODE;
					SEL_BOUNDARY: bsr_d = ring_q;
					default: byp_d = `TAP_BYP_CAPTURE; // R16
				endcase
			end
			SHIFT_DR: begin
				case (dr_sel(ir_q)) // R9 R10
					SEL_IDCODE: id_d = {tdi, id_q[`TAP_ID_W-1:1]};
					SEL_BOUNDARY: bsr_d = {tdi, bsr_q[`TAP_BSR_W-1:1]};
					default: byp_d = tdi; // R16
				endcase
			end
			UPDATE_DR: begin
				if (dr_sel(ir_q) == SEL_BOUNDARY) begin
					upd_d = bsr_q;
				end
			end
			default: begin
			end
		endcase
		// output bus released under sample-z, or extest with the cell low
		hiz_req_d = (ir_q == `TAP_IR_SAMPLE_Z) ||
			((ir_q == `TAP_IR_EXTEST) && !upd_q[`TAP_BSR_OE_BIT]);
		// run of consecutive tms-high edges, saturating
		if (!tms) begin
			tms_run_d = 3'h0;
		end else if (tms_run_q == `TAP_RESET_TMS_EDGES) begin
			tms_run_d = tms_run_q;
		end else begin
			tms_run_d = tms_run_q + 3'h1;
		end
	end

	// test-domain registers; tms and tdi pads are pulled high, so a
	// floating port idles in test-logic-reset
	always_ff @(posedge tck or posedge trst_s2_q) begin // R3 R6 R8
		if (trst_s2_q) begin
			state_q <= TEST_LOGIC_RESET; // R5
			irs_q <= `TAP_IR_IDCODE;
			ir_q <= `TAP_IR_IDCODE; // R14
			byp_q <= `TAP_BYP_CAPTURE;
			id_q <= 32'h0;
			bsr_q <= `TAP_BSR_RST;
			upd_q <= `TAP_BSR_RST;
			ring_s1_q <= `TAP_BSR_RST;
			ring_s2_q <= `TAP_BSR_RST;
			ring_s3_q <= `TAP_BSR_RST;
			ring_q <= `TAP_BSR_RST;
			hiz_req_q <= 1'b0;
			tms_run_q <= 3'h0;
		end else begin
			state_q <= state_d;
			irs_q <= irs_d;
			ir_q <= ir_d;
			byp_q <= byp_d;
			id_q <= id_d;
			bsr_q <= bsr_d;
			upd_q <= upd_d;
			ring_s1_q <= ring_in;
			ring_s2_q <= ring_s1_q;
			ring_s3_q <= ring_s2_q;
			ring_q <= ring_d;
			hiz_req_q <= hiz_req_d;
			tms_run_q <= tms_run_d;
		end
	end

	// -------------------------------------------------------------------
	// test data out, falling tck
	// -------------------------------------------------------------------
	logic tdo_d;
	logic tdo_oe_d;

	// lsb of the selected register, driver on only while shifting
	always_comb begin
		tdo_oe_d = (state_q == SHIFT_IR) || (state_q == SHIFT_DR); // R12 R17
		case (dr_sel(ir_q))
			SEL_IDCODE: tdo_d = id_q[0]; // R11
			SEL_BOUNDARY: tdo_d = bsr_q[0];
			default: tdo_d = byp_q;
		endcase
		if (state_q == SHIFT_IR) begin
			tdo_d = irs_q[0]; // R11
		end
	end

	// outside reset, driver and data change on the falling edge only
	always_ff @(negedge tck or posedge trst_s2_q) begin // R7
		if (trst_s2_q) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0; // R17
		end else begin
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	// -------------------------------------------------------------------
	// output-bus release into the memory clock domain
	// -------------------------------------------------------------------
	logic hiz_s1_q, hiz_s2_q, hiz_s3_q;
	logic q_bus_hiz_d;

	// level counts once second and third stages agree
	always_comb begin
		q_bus_hiz_d = (hiz_s2_q == hiz_s3_q) ? hiz_s3_q : q_bus_hiz_q; // R8
	end

	// memory side never sees a tck-clocked flop directly
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hiz_s1_q <= 1'b0;
			hiz_s2_q <= 1'b0;
			hiz_s3_q <= 1'b0;
			q_bus_hiz_q <= 1'b0;
		end else begin
			hiz_s1_q <= hiz_req_q;
			hiz_s2_q <= hiz_s1_q;
			hiz_s3_q <= hiz_s2_q;
			q_bus_hiz_q <= q_bus_hiz_d;
		end
	end

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	sequence in_reset_s;
		state_q == TEST_LOGIC_RESET;
	endsequence
	sequence byp_shift_s;
		state_q == SHIFT_DR && dr_sel(ir_q) == SEL_BYPASS;
	endsequence
	sequence id_capture_s;
		state_q == CAPTURE_DR && ir_q == `TAP_IR_IDCODE;
	endsequence

	reset_loads_id_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		in_reset_s ##1 1'b1 |-> ir_q == `TAP_IR_IDCODE) // R14
		else $error("instruction not identification after reset");
	five_tms_reset_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		tms_run_q == `TAP_RESET_TMS_EDGES |-> in_reset_s) // R13
		else $error("five tms-high edges did not reset");
	capture_ir_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		state_q == CAPTURE_IR |=> irs_q[1:0] == `TAP_IR_CAPTURE) // R15
		else $error("capture-ir pattern wrong");
	ir_msb_in_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		state_q == SHIFT_IR |=> irs_q[`TAP_IR_W-1] == $past(tdi)) // R10
		else $error("tdi not shifted into instruction msb");
	update_ir_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		state_q == UPDATE_IR |=> ir_q == $past(irs_q)) // R1
		else $error("instruction not taken in update-ir");
	bypass_path_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		byp_shift_s |=> byp_q == $past(tdi)) // R16
		else $error("bypass bit did not follow tdi");
	id_capture_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		id_capture_s ##1 state_q == SHIFT_DR |-> id_q == ID_CODE) // R9
		else $error("identification code not captured");
	tdo_enable_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		$past(trst_s2_q) == 1'b0 |->
		tdo_oe_q == (state_q == SHIFT_IR || state_q == SHIFT_DR)) // R12
		else $error("tdo enable wrong for state");
	tdo_bypass_a: assert property (@(posedge tck) disable iff (trst_s2_q)
		byp_shift_s ##1 byp_shift_s |-> tdo_q == byp_q) // R11
		else $error("tdo not the selected lsb");

endmodule // sram_boundary_scan_tap

// ===== tap_tester.sv
// test controller model driving the boundary-scan link.
// assumes the bench calls step() and owns timing between frames.
`timescale 1ns/1ps

module tap_tester (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_q,
	input wire logic tdo_oe_q
);
	logic last_q;

	// idle: clock parked low, lines at their pulled-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		last_q = 1'b0;
	end

	// one tck period: lines set mid-low, tdo taken at the rising edge
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#23.3 tck = 1'b1;
		o = tdo_oe_q ? tdo_q : ~last_q;
		last_q = o;
		#40 tck = 1'b0;
		#16.7;
	endtask
endmodule // tap_tester

// ===== sram_boundary_scan_tap_test.sv
// self-checking bench for the boundary-scan test access port.
// assumes tap_tester drives the link and tap_defs.svh is on the path.
`timescale 1ns/1ps
`include "tap_defs.svh"

module sram_boundary_scan_tap_test;
	localparam logic [31:0] ID = 32'hA5C3_0F1E; // arbitrary value
	localparam logic [109:0] RING = 110'h2A5F_0C3E_91B7_6D48_F0E1_D2C3;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [`TAP_BSR_W-1:0] ring_in = '0;
	logic tck, tms, tdi, tdo_q, tdo_oe_q, q_bus_hiz_q;
	logic [127:0] d;
	int errors = 0;
	int checks = 0;

	// ----------------------------------------------------------------
	// clock, design and link partner
	// ----------------------------------------------------------------
	always #5 clock = ~clock;

	sram_boundary_scan_tap #(.ID_CODE(ID)) u_sram_boundary_scan_tap (
		.clock(clock), .sys_rst(sys_rst), .tck(tck), .tms(tms),
		.tdi(tdi), .ring_in(ring_in), .tdo_q(tdo_q),
		.tdo_oe_q(tdo_oe_q), .q_bus_hiz_q(q_bus_hiz_q));

	tap_tester u_tap_tester (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// tms bits sent lsb first with tdi high
	task automatic walk(input logic [15:0] m, input int n);
		logic o;
		for (int i = 0; i < n; i++)
			u_tap_tester.step(m[i], 1'b1, o);
	endtask

	// from idle: shift n bits through ir or dr, then update and idle
	task automatic scan(input logic ir, input int n,
		input logic [127:0] din, output logic [127:0] dout);
		dout = '0;
		walk(ir ? 16'h3 : 16'h1, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
			u_tap_tester.step(i == n - 1, din[i], dout[i]);
		walk(16'h1, 2);
		chk(tdo_oe_q, 1'b0);
	endtask

	// idle tck edges carry the request out of the test domain
	task automatic wait_hiz(input logic v);
		int i;
		logic o;
		for (i = 0; i < 8 && q_bus_hiz_q !== v; i++)
			u_tap_tester.step(1'b0, 1'b1, o);
		if (i == 8) begin
			errors++;
			complete_run();
		end
		chk(q_bus_hiz_q, v);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(tdo_oe_q, 1'b0);
		chk(q_bus_hiz_q, 1'b0);
		walk(16'h1F, 6);
	endtask

	task automatic t_idcode();
		scan(1'b0, 32, '1, d);
		chk(d[31:0], ID);
	endtask

	task automatic t_bypass();
		scan(1'b1, 3, 128'h7, d);
		chk(d[2:0], 3'h1);
		scan(1'b0, 8, 128'hB4, d);
		chk(d[7:0], 8'h68);
	endtask

	// private code acts as bypass, then reset from inside shift-dr
	task automatic t_reset5();
		scan(1'b1, 3, 128'h5, d);
		scan(1'b0, 4, 128'hF, d);
		chk(d[3:0], 4'hE);
		walk(16'h00F9, 9);
		scan(1'b0, 32, '1, d);
		chk(d[31:0], ID);
	endtask

	task automatic t_samplez();
		scan(1'b1, 3, 128'h2, d);
		wait_hiz(1'b1);
		walk(16'h1F, 6);
		wait_hiz(1'b0);
	endtask

	// ring captured, then tdi bits come round after the full length
	task automatic t_boundary();
		scan(1'b1, 3, 128'h4, d);
		scan(1'b0, 118, {18'h0, RING}, d);
		chk(d[109:0], RING);
		chk(d[117:110], RING[7:0]);
	endtask

	// extest floats the bus until cell 109 is updated high
	task automatic t_extest();
		ring_in = ~RING;
		scan(1'b1, 3, 128'h0, d);
		chk(d[2:0], 3'h1);
		wait_hiz(1'b1);
		scan(1'b0, 110, {18'h0, 1'h1, 109'h0}, d);
		chk(d[109:0], ring_in);
		wait_hiz(1'b0);
	endtask

	// tdo and its enable only move while tck is low
	always @(tdo_q or tdo_oe_q)
		if (!sys_rst && checks > 0)
			chk(tck, 1'b0);

	initial begin
		#300000;
		errors++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		ring_in = RING;
		@(posedge clock);
		#1 t_reset();
		t_idcode();
		t_bypass();
		t_reset5();
		t_samplez();
		t_boundary();
		t_extest();
		complete_run();
	end
endmodule // sram_boundary_scan_tap_test
